// *** hw/rpl_pkg.sv ***
// Constants, types and shared helpers for the reversible pulse link port
package rpl_pkg;

  // Decoded link pulse: presence, long or short, polarity (+1 when pos)
  typedef struct packed {
    logic valid;
    logic is_long;
    logic pos;
  } rpl_pulse_t;

  // Link port states, one-hot
  typedef enum logic [3:0] {
    RPL_IDLE   = 4'h1,
    RPL_WAKING = 4'h2,
    RPL_READY  = 4'h4,
    RPL_ACTIVE = 4'h8
  } rpl_state_t;

  // Clock and timing figures
  localparam int CLK_PERIOD_NS        = 10;
  localparam int WAKE_QUALIFY_TIME_NS = 240;
  localparam int PORT_SWAP_BLOCK_NS   = 2000;
  localparam int REPLY_WINDOW_NS      = 400;
  localparam int IDLE_TIMEOUT_US      = 5000;
  localparam int WAKE_TIME_US         = 100;
  localparam int READY_TIME_US        = 10;

  // Least times round up to whole cycles
  localparam int WAKE_QUALIFY_CYC =
    (WAKE_QUALIFY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PORT_SWAP_BLOCK_CYC =
    (PORT_SWAP_BLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REPLY_WINDOW_CYC = REPLY_WINDOW_NS / CLK_PERIOD_NS;
  localparam int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int WAKE_TIME_CYC    = WAKE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int READY_TIME_CYC   = READY_TIME_US * 1000 / CLK_PERIOD_NS;

  // Framing figures
  localparam int BYTE_BITS  = 8;
  localparam int CMD_BITS   = 16;
  localparam int CHECK_BITS = 16;

  // Pulse codes
  localparam rpl_pulse_t PULSE_NONE      = 3'h0;
  localparam rpl_pulse_t PULSE_LONG_POS  = 3'h7;
  localparam rpl_pulse_t PULSE_SHORT_NEG = 3'h4;

  // Pulse classification, used on both ports
  function automatic logic is_long_neg(input rpl_pulse_t p);
    return p.valid && p.is_long && !p.pos;
  endfunction

  function automatic logic is_long_pos(input rpl_pulse_t p);
    return p.valid && p.is_long && p.pos;
  endfunction

  function automatic logic is_short(input rpl_pulse_t p);
    return p.valid && !p.is_long;
  endfunction

endpackage

// *** hw/rpl_port.sv ***
// Reversible pulse link port: state, roles, wake-up, forwarding, framing
module rpl_port #(
  parameter int IDLE_CYC  = rpl_pkg::IDLE_TIMEOUT_CYC,
  parameter int WAKE_CYC  = rpl_pkg::WAKE_TIME_CYC,
  parameter int READY_CYC = rpl_pkg::READY_TIME_CYC,
  parameter int BLOCK_CYC = rpl_pkg::PORT_SWAP_BLOCK_CYC,
  parameter int QUAL_CYC  = rpl_pkg::WAKE_QUALIFY_CYC,
  parameter int REPLY_CYC = rpl_pkg::REPLY_WINDOW_CYC
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Strap and core status
  input  wire logic               port_a_mode_select,
  input  wire logic               core_sleeping,
  // Wake activity detectors
  input  wire logic               spi_activity,
  input  wire logic               diff_above_a,
  input  wire logic               diff_above_b,
  // Decoded pulses received on each port
  input  wire rpl_pkg::rpl_pulse_t rx_a,
  input  wire rpl_pkg::rpl_pulse_t rx_b,
  // Core read side
  input  wire logic               core_read_cmd,
  input  wire logic               core_sdo,
  // Pulses to transmit on each port
  output rpl_pkg::rpl_pulse_t     tx_a,
  output rpl_pkg::rpl_pulse_t     tx_b,
  // Link status
  output rpl_pkg::rpl_state_t     link_state,
  output logic                    slave_is_b,
  // Internal serial port toward the core
  output logic                    int_csb_n,
  output logic                    int_sck_pulse,
  output logic                    int_sdi,
  output logic [7:0]              rx_byte,
  output logic                    rx_byte_valid,
  output logic                    read_start,
  output logic                    write_commit,
  // Data returned from the chain above
  output logic                    chain_bit,
  output logic                    chain_bit_valid
);
  import rpl_pkg::*;
  // Counter width covers the longest timing
  localparam int CW = 24;
  // Refuse timings that do not fit the counters
  if (IDLE_CYC < 2 || IDLE_CYC >= (1 << CW) || WAKE_CYC < 1 ||
      WAKE_CYC >= (1 << CW) || READY_CYC < 1 || READY_CYC >= (1 << CW) ||
      BLOCK_CYC < 1 || BLOCK_CYC >= (1 << CW) || QUAL_CYC < 1 ||
      QUAL_CYC >= (1 << CW) || REPLY_CYC < 1 || REPLY_CYC >= (1 << CW))
  begin : g_bad_param
    $error("rpl_port: timing parameter out of range");
  end
  // State and role registers
  rpl_state_t  state_reg;        // Current link state
  rpl_state_t  state_next;       // Next link state
  logic        slave_b_reg;      // Port B is slave when set
  logic        woke_a_reg;       // Last wake came in on port A
  // Timers
  logic [CW-1:0] idle_cnt_reg;   // Cycles without activity
  logic [CW-1:0] wake_cnt_reg;   // Power-up countdown
  logic [CW-1:0] blk_cnt_reg;    // Cycles since last transmit
  logic [CW-1:0] qual_a_reg;     // Port A differential dwell
  logic [CW-1:0] qual_b_reg;     // Port B differential dwell
  logic [CW-1:0] win_cnt_reg;    // Reply listening window
  // Framing registers
  logic [7:0]  shift_reg;        // Byte being assembled
  logic [2:0]  bit_in_byte_reg;  // Bit position inside byte
  logic [5:0]  bit_total_reg;    // Bits since CSB fall, saturating
  logic        read_mode_reg;    // Current command is a read
  logic        got_zero_reg;     // Chain answered with a zero
  // Output registers
  rpl_pulse_t  tx_a_reg;
  rpl_pulse_t  tx_b_reg;
  logic        sck_reg;
  logic        sdi_reg;
  logic [7:0]  byte_reg;
  logic        byte_vld_reg;
  logic        rd_start_reg;
  logic        commit_reg;
  logic        cbit_reg;
  logic        cbit_vld_reg;
  logic        csb_n_reg;
  // Role-relative views of the ports
  rpl_pulse_t  rx_slave;
  rpl_pulse_t  rx_master;
  logic        activity;
  logic        wake_a;
  logic        wake_b;
  logic        idle_hit;
  logic        wake_done;
  logic        block_done;
  logic        start_comm;
  logic        end_comm;
  logic        swap_ok;
  logic        data_bit;
  assign rx_slave  = slave_b_reg ? rx_b : rx_a;
  assign rx_master = slave_b_reg ? rx_a : rx_b;
  // Any line activity restarts the idle timer
  assign activity = rx_a.valid || rx_b.valid || diff_above_a ||
                    diff_above_b || spi_activity;
  assign idle_hit = idle_cnt_reg == CW'(IDLE_CYC - 1);
  // Port A wakes on SPI lines in SPI mode, else its pair; B always pair
  assign wake_a = port_a_mode_select ?
                  (diff_above_a && qual_a_reg == CW'(QUAL_CYC - 1)) :
                  spi_activity;
  assign wake_b = diff_above_b &&
                  qual_b_reg == CW'(QUAL_CYC - 1);
  assign wake_done  = wake_cnt_reg == '0;
  assign block_done = blk_cnt_reg >= CW'(BLOCK_CYC);
  // Communication events in the current state
  assign start_comm = state_reg == RPL_READY &&
                      (is_long_neg(rx_a) || is_long_neg(rx_b));
  assign end_comm   = state_reg == RPL_ACTIVE &&
                      is_long_pos(rx_slave);
  // Early master long pulses may be reflections and are dropped
  assign swap_ok    = state_reg == RPL_ACTIVE && !end_comm &&
                      is_long_neg(rx_master) && block_done;
  assign data_bit   = state_reg == RPL_ACTIVE && is_short(rx_slave);
  // Next-state decode
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RPL_IDLE: begin
        if (wake_a || wake_b) begin
          state_next = RPL_WAKING;
        end
      end
      RPL_WAKING: begin
        if (wake_done) begin
          state_next = RPL_READY;
        end
      end
      RPL_READY: begin
        if (start_comm) begin
          state_next = RPL_ACTIVE;
        end else if (idle_hit) begin
          state_next = RPL_IDLE;
        end
      end
      RPL_ACTIVE: begin
        if (end_comm) begin
          state_next = RPL_READY;
        end else if (idle_hit) begin
          state_next = RPL_IDLE;
        end
      end
      default: state_next = RPL_IDLE;
    endcase
  end
  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= RPL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  // Port roles and wake source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slave_b_reg <= 1'b0;
      woke_a_reg  <= 1'b0;
    end else begin
      if (state_reg == RPL_IDLE && (wake_a || wake_b)) begin
        woke_a_reg <= wake_a;      // A wins if both qualify together
      end
      if (start_comm) begin
        // Receiving port becomes slave; A wins a tie
        slave_b_reg <= !is_long_neg(rx_a);
      end else if (swap_ok) begin
        slave_b_reg <= !slave_b_reg;
      end
    end
  end
  // Idle and power-up timers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt_reg <= '0;
      wake_cnt_reg <= '0;
    end else begin
      if (activity || state_reg == RPL_IDLE || idle_hit) begin
        idle_cnt_reg <= '0;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 1'b1;
      end
      if (state_reg == RPL_IDLE) begin
        // Sleeping core takes the longer wake time
        wake_cnt_reg <= core_sleeping ? CW'(WAKE_CYC - 1) :
                                        CW'(READY_CYC - 1);
      end else if (!wake_done) begin
        wake_cnt_reg <= wake_cnt_reg - 1'b1;
      end
    end
  end
  // Wake qualification: dwell must be unbroken; common mode never reaches
  // the differential detectors
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      qual_a_reg <= '0;
      qual_b_reg <= '0;
    end else begin
      if (!diff_above_a) begin
        qual_a_reg <= '0;
      end else if (qual_a_reg != CW'(QUAL_CYC - 1)) begin
        qual_a_reg <= qual_a_reg + 1'b1;
      end
      if (!diff_above_b) begin
        qual_b_reg <= '0;
      end else if (qual_b_reg != CW'(QUAL_CYC - 1)) begin
        qual_b_reg <= qual_b_reg + 1'b1;
      end
    end
  end

  // Block timer restarts on every pulse this port sends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blk_cnt_reg <= '0;
    end else if (tx_a_reg.valid || tx_b_reg.valid) begin
      blk_cnt_reg <= '0;
    end else if (!block_done) begin
      blk_cnt_reg <= blk_cnt_reg + 1'b1;
    end
  end

  // Transmit side: wake propagation, forwarding and read replies
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_a_reg <= PULSE_NONE;
      tx_b_reg <= PULSE_NONE;
    end else begin
      tx_a_reg <= PULSE_NONE;
      tx_b_reg <= PULSE_NONE;
      if (state_reg == RPL_WAKING && wake_done) begin
        // Only the power-up path sends this, never from ready
        if (woke_a_reg) begin
          tx_b_reg <= PULSE_LONG_POS;
        end
      end else if (start_comm) begin
        if (is_long_neg(rx_a)) begin
          tx_b_reg <= rx_a;
        end else begin
          tx_a_reg <= rx_b;
        end
      end else if (swap_ok) begin
        // New master is the old slave
        if (slave_b_reg) begin
          tx_b_reg <= rx_a;
        end else begin
          tx_a_reg <= rx_b;
        end
      end else if (state_reg == RPL_ACTIVE && rx_slave.valid) begin
        // Forward everything from the slave side, answer zeros only
        if (slave_b_reg) begin
          tx_a_reg <= rx_slave;
          if (data_bit && read_mode_reg && !core_sdo) begin
            tx_b_reg <= PULSE_SHORT_NEG;
          end
        end else begin
          tx_b_reg <= rx_slave;
          if (data_bit && read_mode_reg && !core_sdo) begin
            tx_a_reg <= PULSE_SHORT_NEG;
          end
        end
      end
    end
  end

  // Internal serial port rebuilt from slave pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csb_n_reg <= 1'b1;
      sck_reg   <= 1'b0;
      sdi_reg   <= 1'b0;
    end else begin
      csb_n_reg <= state_next != RPL_ACTIVE;
      sck_reg   <= data_bit;
      if (data_bit) begin
        sdi_reg <= rx_slave.pos;
      end
    end
  end

  // Byte framing, read decode and write commit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_reg       <= '0;
      bit_in_byte_reg <= '0;
      bit_total_reg   <= '0;
      read_mode_reg   <= 1'b0;
      byte_reg        <= '0;
      byte_vld_reg    <= 1'b0;
      rd_start_reg    <= 1'b0;
      commit_reg      <= 1'b0;
    end else begin
      byte_vld_reg <= 1'b0;
      rd_start_reg <= 1'b0;
      // Commit only writes, and only when CSB rises
      commit_reg   <= end_comm && !read_mode_reg &&
                      bit_total_reg != '0;
      if (start_comm || end_comm || state_reg != RPL_ACTIVE) begin
        shift_reg       <= '0;
        bit_in_byte_reg <= '0;
        bit_total_reg   <= '0;
        read_mode_reg   <= 1'b0;
      end else if (data_bit) begin
        // First bit lands in the MSB position
        shift_reg       <= {shift_reg[6:0], rx_slave.pos};
        bit_in_byte_reg <= bit_in_byte_reg + 1'b1;
        if (bit_in_byte_reg == 3'(BYTE_BITS - 1)) begin
          byte_reg     <= {shift_reg[6:0], rx_slave.pos};
          byte_vld_reg <= 1'b1;
        end
        if (bit_total_reg != 6'(CMD_BITS + CHECK_BITS)) begin
          bit_total_reg <= bit_total_reg + 1'b1;
        end
        if (bit_total_reg == 6'(CMD_BITS + CHECK_BITS - 1)) begin
          // Core decode of the command and check code is sampled here
          rd_start_reg  <= core_read_cmd;
          read_mode_reg <= core_read_cmd;
        end
      end
    end
  end

  // Chain reply capture: silence inside the window reads as one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_cnt_reg  <= '0;
      got_zero_reg <= 1'b0;
      cbit_reg     <= 1'b0;
      cbit_vld_reg <= 1'b0;
    end else begin
      cbit_vld_reg <= 1'b0;
      if (data_bit && read_mode_reg) begin
        win_cnt_reg  <= CW'(REPLY_CYC);
        got_zero_reg <= 1'b0;
      end else if (win_cnt_reg != '0) begin
        win_cnt_reg <= win_cnt_reg - 1'b1;
        if (rx_master.valid && !rx_master.is_long && !rx_master.pos) begin
          got_zero_reg <= 1'b1;
        end
        if (win_cnt_reg == CW'(1)) begin
          // Upstream bit handed to the core shift chain behind own data
          cbit_reg     <= !got_zero_reg;
          cbit_vld_reg <= 1'b1;
        end
      end
    end
  end

  // Outputs straight from registers
  assign tx_a            = tx_a_reg;
  assign tx_b            = tx_b_reg;
  assign link_state      = state_reg;
  assign slave_is_b      = slave_b_reg;
  assign int_csb_n       = csb_n_reg;
  assign int_sck_pulse   = sck_reg;
  assign int_sdi         = sdi_reg;
  assign rx_byte         = byte_reg;
  assign rx_byte_valid   = byte_vld_reg;
  assign read_start      = rd_start_reg;
  assign write_commit    = commit_reg;
  assign chain_bit       = cbit_reg;
  assign chain_bit_valid = cbit_vld_reg;

endmodule

// *** testbench/rpl_chk.sv ***
// Checker: role, state and pulse relations at the link port's pins
module rpl_chk #(
  parameter int WAKE_CYC  = 20,
  parameter int READY_CYC = 10,
  parameter int BLOCK_CYC = 8
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // Watched pins
  input wire logic                core_sleeping,
  input wire rpl_pkg::rpl_pulse_t rx_a,
  input wire rpl_pkg::rpl_pulse_t rx_b,
  input wire rpl_pkg::rpl_pulse_t tx_a,
  input wire rpl_pkg::rpl_pulse_t tx_b,
  input wire rpl_pkg::rpl_state_t link_state,
  input wire logic                slave_is_b,
  input wire logic                int_csb_n,
  input wire logic                int_sck_pulse,
  input wire logic                int_sdi,
  input wire logic                read_start,
  input wire logic                write_commit
);
  timeunit 1ns;
  timeprecision 1ps;
  import rpl_pkg::*;
  localparam rpl_pulse_t LNEG = 3'h6; // Long -1
  localparam int RB = READY_CYC + 2;  // Standby bound, with margin
  localparam int WB = WAKE_CYC + 2;   // Sleep bound, with margin
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Pulses seen from the slave side and the master side
  rpl_pulse_t s_rx, m_rx, s_tx, m_tx;
  logic       act;
  assign s_rx = slave_is_b ? rx_b : rx_a;
  assign m_rx = slave_is_b ? rx_a : rx_b;
  assign s_tx = slave_is_b ? tx_b : tx_a;
  assign m_tx = slave_is_b ? tx_a : tx_b;
  assign act  = link_state == RPL_ACTIVE;
  // Cycles since the last transmit; margin of two keeps timer skew out
  logic [7:0] quiet_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      quiet_reg <= 8'hff;
    else if (tx_a.valid || tx_b.valid)
      quiet_reg <= 8'h00;
    else if (quiet_reg != 8'hff)
      quiet_reg <= quiet_reg + 8'h01;
  end
  a_start_on_a : assert property (
    link_state == RPL_READY && rx_a == LNEG
    |=> act && !slave_is_b && tx_b == LNEG)
    else $error("start on port A wrong");
  a_start_on_b : assert property (
    link_state == RPL_READY && rx_b == LNEG && rx_a != LNEG
    |=> act && slave_is_b && tx_a == LNEG)
    else $error("start on port B wrong");
  a_active_csb : assert property (
    !int_csb_n == act) else $error("internal CSB not tied to active");
  a_end_ready : assert property (
    act && s_rx == PULSE_LONG_POS |=> link_state == RPL_READY && int_csb_n)
    else $error("slave long +1 did not end");
  a_block_ignore : assert property (
    act && m_rx.valid && m_rx.is_long && quiet_reg <= BLOCK_CYC - 3
    |=> act && $stable(slave_is_b) && !s_tx.valid)
    else $error("pulse inside block time acted on");
  a_swap_late : assert property (
    act && m_rx == LNEG && quiet_reg >= BLOCK_CYC + 2
    |=> slave_is_b != $past(slave_is_b))
    else $error("late master long -1 did not swap");
  a_ready_quiet : assert property (
    link_state == RPL_READY && $past(link_state) == RPL_READY
    |-> !tx_a.valid && !tx_b.valid) else $error("ready port transmitted");
  a_slave_short : assert property (
    act && $past(link_state) == RPL_ACTIVE && $stable(slave_is_b)
    && s_tx.valid |-> s_tx == PULSE_SHORT_NEG)
    else $error("slave port sent other than short -1");
  a_wake_time : assert property (
    link_state == RPL_WAKING && $past(link_state) == RPL_IDLE && core_sleeping
    |-> ##[1:WB] link_state == RPL_READY) else $error("wake too slow");
  a_ready_time : assert property (
    link_state == RPL_WAKING && $past(link_state) == RPL_IDLE && !core_sleeping
    |-> ##[1:RB] link_state == RPL_READY) else $error("ready too slow");
  a_bit_forward : assert property (
    act && s_rx.valid && !s_rx.is_long
    |=> int_sck_pulse && int_sdi == $past(s_rx.pos) && m_tx == $past(s_rx))
    else $error("data bit not strobed or forwarded");
  // Main scenarios reached
  c_start : cover property (link_state == RPL_READY ##1 act);
  c_read  : cover property (read_start);
  c_write : cover property (write_commit);
  c_swap  : cover property (act && $changed(slave_is_b));
endmodule

// *** testbench/rpl_peer.sv ***
// Far-side partner: sends decoded pulses, answers forwarded read bits
module rpl_peer (
  // Clock
  input wire logic                clk,
  // Device side of the link
  input wire rpl_pkg::rpl_pulse_t tx_a,
  input wire rpl_pkg::rpl_pulse_t tx_b,
  input wire logic                slave_is_b,
  // Answer forwarded bits with a zero
  input wire logic                reply_zero,
  // Decoded pulses into the device
  output rpl_pkg::rpl_pulse_t     rx_a,
  output rpl_pkg::rpl_pulse_t     rx_b
);
  timeunit 1ns;
  timeprecision 1ps;
  import rpl_pkg::*;
  logic [2:0] dly = 3'h0; // Reply delay line
  rpl_pulse_t m_tx;       // Pulse leaving the master port
  assign m_tx = slave_is_b ? tx_a : tx_b;
  initial begin
    rx_a = PULSE_NONE;
    rx_b = PULSE_NONE;
  end
  // One pulse per call, one cycle wide, launched just after an edge
  task automatic send(input logic on_b, input rpl_pulse_t p);
    @(posedge clk);
    if (on_b)
      rx_b <= p;
    else
      rx_a <= p;
    @(posedge clk);
    rx_a <= PULSE_NONE;
    rx_b <= PULSE_NONE;
  endtask
  // Chain above: a zero returns as short -1 only; silence means one
  always @(posedge clk) begin
    dly <= {dly[1:0], reply_zero && m_tx.valid && !m_tx.is_long};
    if (dly[1] && slave_is_b)
      rx_a <= PULSE_SHORT_NEG;
    else if (dly[1])
      rx_b <= PULSE_SHORT_NEG;
    if (dly[2]) begin
      rx_a <= PULSE_NONE;
      rx_b <= PULSE_NONE;
    end
  end
endmodule

// *** testbench/tb_top.sv ***
// Top bench: wake, start, read, write and port swap of the link port
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rpl_pkg::*;
  localparam int IDLE = 200, WAKE = 20, RDY = 10, BLK = 8, REP = 6;
  localparam rpl_pulse_t LNEG = 3'h6; // Long -1
  localparam rpl_pulse_t SPOS = 3'h5; // Short +1
  // Inputs of the port
  logic       clk = 1'b0, rst = 1'b1, mode = 1'b1, sleeping = 1'b1;
  logic       spi_act = 1'b0, dia = 1'b0, dib = 1'b0;
  logic       rd_cmd = 1'b0, sdo = 1'b1, reply_zero = 1'b0;
  // Outputs and what the monitor latched
  rpl_pulse_t rx_a, rx_b, tx_a, tx_b;
  rpl_pulse_t last_a = PULSE_NONE, last_b = PULSE_NONE;
  rpl_state_t link_state;
  logic       slave_is_b, int_csb_n, int_sck_pulse, int_sdi, rx_byte_valid;
  logic       read_start, write_commit, chain_bit, chain_bit_valid;
  logic [7:0] rx_byte, byte_seen;
  logic       rs_seen = 1'b0, wc_seen = 1'b0;
  logic [1:0] chain_seen = 2'b00;
  int         mismatches = 0, tests_run = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  // Short counts keep the run brief
  rpl_port #(.IDLE_CYC(IDLE), .WAKE_CYC(WAKE), .READY_CYC(RDY),
    .BLOCK_CYC(BLK), .QUAL_CYC(24), .REPLY_CYC(REP)) rpl_port_inst (
    .clk(clk), .rst(rst), .port_a_mode_select(mode),
    .core_sleeping(sleeping), .spi_activity(spi_act),
    .diff_above_a(dia), .diff_above_b(dib), .rx_a(rx_a), .rx_b(rx_b),
    .core_read_cmd(rd_cmd), .core_sdo(sdo), .tx_a(tx_a), .tx_b(tx_b),
    .link_state(link_state), .slave_is_b(slave_is_b),
    .int_csb_n(int_csb_n), .int_sck_pulse(int_sck_pulse),
    .int_sdi(int_sdi), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
    .read_start(read_start), .write_commit(write_commit),
    .chain_bit(chain_bit), .chain_bit_valid(chain_bit_valid));
  rpl_peer rpl_peer_inst (.clk(clk), .tx_a(tx_a), .tx_b(tx_b),
    .slave_is_b(slave_is_b), .reply_zero(reply_zero),
    .rx_a(rx_a), .rx_b(rx_b));
  // Latch pulses and strobes; strobes stand one cycle only
  always @(posedge clk) begin
    if (tx_a.valid)
      last_a <= tx_a;
    if (tx_b.valid)
      last_b <= tx_b;
    if (rx_byte_valid)
      byte_seen <= rx_byte;
    if (read_start)
      rs_seen <= 1'b1;
    if (write_commit)
      wc_seen <= 1'b1;
    if (chain_bit_valid)
      chain_seen <= {1'b1, chain_bit};
  end
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Clear latches away from the sampling edge
  task automatic clr();
    @(negedge clk);
    last_a = PULSE_NONE;
    last_b = PULSE_NONE;
    rs_seen = 1'b0;
    wc_seen = 1'b0;
    chain_seen = 2'b00;
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait for a state; running out ends the run
  task automatic wait_state(input rpl_state_t s, input int lim);
    int n;
    n = 0;
    // Start off the edge so a state launched this step is not raced
    @(negedge clk);
    while (link_state !== s && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (link_state !== s) begin
      chk(1'b0, "state wait timed out");
      complete_run();
    end
    // One more edge lets the monitor latch pulses sent on entry
    @(negedge clk);
  endtask
  task automatic t_wake_a();
    @(posedge clk);
    dia <= 1'b1;
    repeat (22) @(posedge clk);
    dia <= 1'b0;
    repeat (6) @(negedge clk);
    chk(link_state === RPL_IDLE, "short burst woke link");
    @(posedge clk);
    dia <= 1'b1;
    repeat (26) @(posedge clk);
    dia <= 1'b0;
    wait_state(RPL_READY, WAKE + 20);
    chk(last_b === PULSE_LONG_POS && last_a === PULSE_NONE, "A wake");
    clr();
    @(posedge clk);
    dia <= 1'b1;
    repeat (30) @(posedge clk);
    dia <= 1'b0;
    repeat (4) @(negedge clk);
    chk(last_b === PULSE_NONE, "ready link propagated wake");
    // Host waits the ready time after its dummy traffic
    repeat (RDY) @(negedge clk);
    chk(link_state === RPL_READY, "not ready after dummy");
    $display("test wake_a done");
  endtask
  task automatic t_wake_b();
    clr();
    wait_state(RPL_IDLE, IDLE + 40);
    @(posedge clk);
    sleeping <= 1'b0;
    dib <= 1'b1;
    repeat (26) @(posedge clk);
    dib <= 1'b0;
    wait_state(RPL_READY, RDY + 20);
    chk(last_a === PULSE_NONE && last_b === PULSE_NONE, "B wake sent");
    // Second long pulse of the host's wake pair, inside the idle time
    rpl_peer_inst.send(1'b1, PULSE_LONG_POS);
    @(negedge clk);
    chk(link_state === RPL_READY, "wake pair upset ready");
    wait_state(RPL_IDLE, IDLE + 40);
    @(posedge clk);
    mode <= 1'b0;
    spi_act <= 1'b1;
    @(posedge clk);
    spi_act <= 1'b0;
    wait_state(RPL_READY, RDY + 20);
    chk(last_b === PULSE_LONG_POS, "no long +1 after SPI wake");
    $display("test wake_b done");
  endtask
  task automatic t_read();
    logic [31:0] cmd = 32'h3c5a_96a5;
    clr();
    rpl_peer_inst.send(1'b0, LNEG);
    wait_state(RPL_ACTIVE, 5);
    chk(!slave_is_b && !int_csb_n && last_b === LNEG, "start A");
    @(posedge clk);
    rd_cmd <= 1'b1;
    // No long pulse between bits: CSB stays low throughout
    for (int i = 0; i < CMD_BITS + CHECK_BITS; i++)
      rpl_peer_inst.send(1'b0, {2'b10, cmd[31 - i]});
    repeat (2) @(negedge clk);
    chk(byte_seen === 8'ha5 && last_b === SPOS, "byte or forward");
    chk(rs_seen === 1'b1, "read not decoded");
    clr();
    @(posedge clk);
    sdo <= 1'b0;
    reply_zero <= 1'b1;
    rpl_peer_inst.send(1'b0, SPOS);
    repeat (REP + 4) @(negedge clk);
    chk(last_a === PULSE_SHORT_NEG && chain_seen === 2'b10, "zero");
    clr();
    @(posedge clk);
    sdo <= 1'b1;
    reply_zero <= 1'b0;
    rpl_peer_inst.send(1'b0, SPOS);
    repeat (REP + 4) @(negedge clk);
    chk(last_a === PULSE_NONE && chain_seen === 2'b11, "one");
    rpl_peer_inst.send(1'b0, PULSE_LONG_POS);
    wait_state(RPL_READY, 5);
    chk(int_csb_n && last_b === PULSE_LONG_POS && !wc_seen, "end");
    $display("test read done");
  endtask
  task automatic t_swap();
    clr();
    @(posedge clk);
    rd_cmd <= 1'b0;
    rpl_peer_inst.send(1'b0, LNEG);
    rpl_peer_inst.send(1'b1, LNEG);
    rpl_peer_inst.send(1'b0, SPOS);
    repeat (2) @(negedge clk);
    chk(!slave_is_b && last_a === PULSE_NONE, "swap in block time");
    repeat (BLK + 4) @(posedge clk);
    rpl_peer_inst.send(1'b1, LNEG);
    repeat (2) @(negedge clk);
    chk(slave_is_b === 1'b1 && last_a === LNEG, "late swap");
    rpl_peer_inst.send(1'b1, PULSE_LONG_POS);
    wait_state(RPL_READY, 5);
    chk(wc_seen === 1'b1 && int_csb_n === 1'b1, "write commit");
    // Start from port B: A becomes master and carries the long -1
    clr();
    rpl_peer_inst.send(1'b1, LNEG);
    wait_state(RPL_ACTIVE, 5);
    chk(slave_is_b === 1'b1 && last_a === LNEG, "start B");
    rpl_peer_inst.send(1'b1, PULSE_LONG_POS);
    wait_state(RPL_READY, 5);
    chk(last_a === PULSE_LONG_POS && !wc_seen, "end B");
    $display("test swap done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_wake_a();
    t_wake_b();
    t_read();
    t_swap();
    complete_run();
  end
endmodule
bind rpl_port rpl_chk #(.WAKE_CYC(WAKE_CYC), .READY_CYC(READY_CYC),
  .BLOCK_CYC(BLOCK_CYC)) rpl_chk_inst (.clk(clk), .rst(rst),
  .core_sleeping(core_sleeping), .rx_a(rx_a), .rx_b(rx_b), .tx_a(tx_a),
  .tx_b(tx_b), .link_state(link_state), .slave_is_b(slave_is_b),
  .int_csb_n(int_csb_n), .int_sck_pulse(int_sck_pulse), .int_sdi(int_sdi),
  .read_start(read_start), .write_commit(write_commit));
